/* include/tmk_map.svh */
`ifndef TMK_MAP_SVH
`define TMK_MAP_SVH

// ---------------------------------------------------------------
// Stream geometry
// ---------------------------------------------------------------
`define TMK_NCH        12
`define TMK_SAMPLE_W   10
`define TMK_CNT_W      7
`define TMK_FINE_W     5
`define TMK_COARSE_W   7
`define TMK_HOLD_W     9
`define TMK_SETTLE_W   16
`define TMK_HITS_W     4

// ---------------------------------------------------------------
// Tick mark timing in clock cycles, header run length and last fine phase step
// ---------------------------------------------------------------
`define TMK_PERIOD     7'd70
`define TMK_TICK_POS   7'd68
`define TMK_LAST_POS   7'd69
`define TMK_CNT_ZERO   7'd0
`define TMK_HDR_RUN    2'd3
`define TMK_FINE_LAST  5'h1F

// ---------------------------------------------------------------
// Filters and buffering
// ---------------------------------------------------------------
`define TMK_IIR_SHIFT  4
`define TMK_FIFO_SLACK 4

`endif

/* include/tmk_pkg.sv */
package tmk_pkg;
`include "tmk_map.svh"

    typedef logic [`TMK_SAMPLE_W-1:0]  tmk_sample_t;
    typedef tmk_sample_t [`TMK_NCH-1:0] tmk_word_t;

    typedef struct packed {
        logic [`TMK_FINE_W-1:0]   fine;
        logic [`TMK_COARSE_W-1:0] coarse;
    } tmk_skew_t;

    typedef tmk_skew_t [`TMK_NCH-1:0] tmk_skews_t;

    typedef struct packed {
        tmk_sample_t avg;
        tmk_sample_t hi;
        tmk_sample_t lo;
        tmk_sample_t thr;
    } tmk_thr_t;

    typedef struct packed {
        logic [`TMK_CNT_W-1:0]  cnt;
        logic                   lock;
        logic                   high;
        logic [1:0]             run;
        logic [`TMK_HOLD_W-1:0] hold;
        logic                   pulse;
    } tmk_trk_t;

    typedef enum logic [1:0] {TMK_CAL_IDLE, TMK_CAL_SETTLE, TMK_CAL_STEP, TMK_CAL_COARSE}
        tmk_cal_t;

    typedef struct packed {
        tmk_word_t                        sync1_data;
        tmk_word_t                        sync2_data;
        logic                             sync1_valid;
        logic                             sync2_valid;
        tmk_thr_t [`TMK_NCH-1:0]          thr;
        tmk_trk_t [`TMK_NCH-1:0]          trk;
        logic [`TMK_NCH-1:0]              start_event;
        tmk_word_t                        data_out;
        logic                             data_valid;
        tmk_cal_t                         cal;
        logic [`TMK_SETTLE_W-1:0]         settle;
        logic [`TMK_NCH-1:0][`TMK_FINE_W-1:0] best;
        tmk_skews_t                       skew;
    } tmk_top_state_t;

endpackage

/* logic/tmk_top.sv */
`timescale 1ns/100ps
// Summary of operation
// - Twelve independent channels of 10-bit fibre samples are accepted, one per fibre.
// - Each tracker runs a counter that cycles through 70 positions, advancing only when a sample word is consumed.
// - A tracker is locked when its counter position matches the arrival of the tick marks.
// - An unlocked tracker sets its counter to the last tick position on each misplaced tick edge until the timing matches again.
// - The decision threshold sits midway between the low and high levels of the data.
// - The threshold is dynamic and is built from three IIR filters that track the data.
// - Each locked tracker emits one pulse when it sees a frame header in its stream.
// - The master takes all twelve pulses and counts how many fired in the same cycle.
// - On enough coincident pulses an event start goes to every channel at once.
// - Each converter clock phase is set in thirty-second steps of a clock period.
// - Skew settings load manually or come from an automatic calibration run.
// - A tick is 68 cycles low then 2 cycles high, repeating every 70 cycles.

`include "tmk_map.svh"

// ---------------------------------------------------------------
// Sample buffer
// ---------------------------------------------------------------
module tmk_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 count;
        logic                        ready;
    } tmk_fifo_state_t;

    tmk_fifo_state_t s;
    tmk_fifo_state_t next_s;
    logic            push;
    logic            pop;

    assign out_valid = (s.count != '0);
    assign out_data  = s.mem[s.rd];
    assign in_ready  = s.ready;
    assign pop       = out_valid & out_ready;
    // Writes past full are dropped; ready leaves slack for sync latency
    assign push      = in_valid & (s.count != (AW+1)'(DEPTH));

    always_comb
    begin
        next_s = s;
        if (push)
        begin
            next_s.mem[s.wr] = in_data;
            next_s.wr        = (s.wr == AW'(DEPTH-1)) ? '0 : s.wr + 1'b1;
        end
        if (pop)
        begin
            next_s.rd = (s.rd == AW'(DEPTH-1)) ? '0 : s.rd + 1'b1;
        end
        next_s.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
        next_s.ready = (next_s.count <= (AW+1)'(DEPTH - `TMK_FIFO_SLACK));
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s       <= '0;
            s.ready <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end
endmodule // tmk_fifo

// ---------------------------------------------------------------
// Tick lock, threshold, coincidence and skew control
// ---------------------------------------------------------------
module tmk_top #(
    parameter int                      DEPTH      = 8,
    parameter logic [`TMK_HOLD_W-1:0]  FRAME_HOLD = 9'h100,
    parameter logic [`TMK_SETTLE_W-1:0] CAL_SETTLE = 16'h0400
) (
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire tmk_pkg::tmk_word_t raw_data,
    input  wire logic               raw_valid,
    output logic                    raw_ready,
    input  wire logic               proc_hold,
    input  wire logic [`TMK_HITS_W-1:0] min_hits,
    input  wire logic               manual_load,
    input  wire tmk_pkg::tmk_skews_t manual_skew,
    input  wire logic               cal_start,
    output tmk_pkg::tmk_skews_t     skew,
    output logic                    cal_busy,
    output logic [`TMK_NCH-1:0]     chan_locked,
    output logic [`TMK_NCH-1:0]     header_seen,
    output logic [`TMK_NCH-1:0]     start_event,
    output tmk_pkg::tmk_word_t      data_out,
    output logic                    data_valid
);
    localparam int WW = `TMK_NCH * `TMK_SAMPLE_W;

    tmk_pkg::tmk_top_state_t s;
    tmk_pkg::tmk_top_state_t next_s;
    logic                    buf_valid;
    logic                    buf_ready;
    logic [WW-1:0]           buf_data;
    tmk_pkg::tmk_word_t      samples;
    logic                    pop;

    // Synchronised samples feed the buffer; the block stalls on proc_hold
    tmk_fifo #(
        .WIDTH (WW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .in_valid  (s.sync2_valid),
        .in_ready  (buf_ready),
        .in_data   (s.sync2_data),
        .out_valid (buf_valid),
        .out_ready (~proc_hold),
        .out_data  (buf_data)
    );

    assign samples     = buf_data;
    assign pop         = buf_valid & ~proc_hold;
    assign skew        = s.skew;
    assign start_event = s.start_event;
    assign data_out    = s.data_out;
    assign data_valid  = s.data_valid;

    always_comb
    begin
        logic [`TMK_SAMPLE_W:0] sum;
        logic                   bit_hi;
        logic [`TMK_CNT_W-1:0]  cnt_nx;
        logic [`TMK_HITS_W-1:0] hits;
        logic [`TMK_CNT_W:0]    diff;
        sum    = '0;
        bit_hi = 1'b0;
        cnt_nx = '0;
        hits   = '0;
        diff   = '0;
        next_s = s;

        next_s.sync1_data  = raw_data;
        next_s.sync2_data  = s.sync1_data;
        next_s.sync1_valid = raw_valid;
        next_s.sync2_valid = s.sync1_valid;
        next_s.start_event = '0;
        next_s.data_valid  = 1'b0;
        for (int c = 0; c < `TMK_NCH; c++)
        begin
            next_s.trk[c].pulse = 1'b0;
        end

        if (pop)
        begin
            next_s.data_out   = samples;
            next_s.data_valid = 1'b1;
            for (int c = 0; c < `TMK_NCH; c++)
            begin
                // Mean, upper and lower trackers; slow so one frame cannot drag them
                next_s.thr[c].avg = tmk_iir(s.thr[c].avg, samples[c]);
                if (samples[c] > s.thr[c].avg)
                begin
                    next_s.thr[c].hi = tmk_iir(s.thr[c].hi, samples[c]);
                end
                else
                begin
                    next_s.thr[c].lo = tmk_iir(s.thr[c].lo, samples[c]);
                end
                sum = {1'b0, s.thr[c].hi} + {1'b0, s.thr[c].lo};
                next_s.thr[c].thr = sum[`TMK_SAMPLE_W:1];

                bit_hi = (samples[c] > s.thr[c].thr);
                cnt_nx = (s.trk[c].cnt == `TMK_LAST_POS) ? `TMK_CNT_ZERO
                                                         : s.trk[c].cnt + 1'b1;
                next_s.trk[c].run  = bit_hi ? ((s.trk[c].run == `TMK_HDR_RUN) ?
                                     `TMK_HDR_RUN : s.trk[c].run + 1'b1) : 2'd0;
                next_s.trk[c].high = bit_hi;
                if (s.trk[c].hold != '0)
                begin
                    // Frame body in flight: tick checks would misfire on data
                    next_s.trk[c].hold = s.trk[c].hold - 1'b1;
                end
                else if (s.trk[c].lock && bit_hi && (next_s.trk[c].run == `TMK_HDR_RUN))
                begin
                    // Ticks are only two high, a third high sample is a header
                    next_s.trk[c].pulse = 1'b1;
                    next_s.trk[c].hold  = FRAME_HOLD;
                end
                else if (bit_hi && !s.trk[c].high)
                begin
                    if (s.trk[c].cnt == `TMK_TICK_POS)
                    begin
                        next_s.trk[c].lock = 1'b1;
                    end
                    else
                    begin
                        next_s.trk[c].lock = 1'b0;
                        cnt_nx             = `TMK_LAST_POS;
                    end
                end
                else if ((s.trk[c].cnt == `TMK_LAST_POS) && !(bit_hi && s.trk[c].high))
                begin
                    next_s.trk[c].lock = 1'b0;
                end
                else if ((s.trk[c].cnt < `TMK_TICK_POS) && bit_hi)
                begin
                    next_s.trk[c].lock = 1'b0;
                end
                next_s.trk[c].cnt = cnt_nx;
                hits = hits + `TMK_HITS_W'(next_s.trk[c].pulse);
            end
            if ((hits != '0) && (hits >= min_hits))
            begin
                next_s.start_event = '1;
            end
        end

        unique case (s.cal)
            tmk_pkg::TMK_CAL_IDLE:
            begin
                if (cal_start)
                begin
                    for (int c = 0; c < `TMK_NCH; c++)
                    begin
                        next_s.skew[c].fine = '0;
                    end
                    next_s.best   = '0;
                    next_s.settle = CAL_SETTLE;
                    next_s.cal    = tmk_pkg::TMK_CAL_SETTLE;
                end
                else if (manual_load)
                begin
                    next_s.skew = manual_skew;
                end
            end
            tmk_pkg::TMK_CAL_SETTLE:
            begin
                next_s.settle = s.settle - 1'b1;
                if (s.settle == '0)
                begin
                    next_s.cal = tmk_pkg::TMK_CAL_STEP;
                end
            end
            tmk_pkg::TMK_CAL_STEP:
            begin
                // Last locked phase wins: latest point before the tick falls
                for (int c = 0; c < `TMK_NCH; c++)
                begin
                    if (s.trk[c].lock)
                    begin
                        next_s.best[c] = s.skew[c].fine;
                    end
                    next_s.skew[c].fine = s.skew[c].fine + 1'b1;
                end
                next_s.settle = CAL_SETTLE;
                next_s.cal    = (s.skew[0].fine == `TMK_FINE_LAST) ? tmk_pkg::TMK_CAL_COARSE
                                                                   : tmk_pkg::TMK_CAL_SETTLE;
            end
            tmk_pkg::TMK_CAL_COARSE:
            begin
                // Whole-cycle delay to line each counter up with channel 0
                for (int c = 0; c < `TMK_NCH; c++)
                begin
                    diff = (s.trk[0].cnt >= s.trk[c].cnt)
                         ? {1'b0, s.trk[0].cnt} - {1'b0, s.trk[c].cnt}
                         : {1'b0, s.trk[0].cnt} + {1'b0, `TMK_PERIOD} - {1'b0, s.trk[c].cnt};
                    next_s.skew[c].fine   = s.best[c];
                    next_s.skew[c].coarse = diff[`TMK_COARSE_W-1:0];
                end
                next_s.cal = tmk_pkg::TMK_CAL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s           <= '0;
            raw_ready   <= 1'b0;
            cal_busy    <= 1'b0;
            chan_locked <= '0;
            header_seen <= '0;
        end
        else
        begin
            s         <= next_s;
            raw_ready <= buf_ready;
            cal_busy  <= (next_s.cal != tmk_pkg::TMK_CAL_IDLE);
            for (int c = 0; c < `TMK_NCH; c++)
            begin
                chan_locked[c] <= next_s.trk[c].lock;
                header_seen[c] <= next_s.trk[c].pulse;
            end
        end
    end

    function automatic tmk_pkg::tmk_sample_t tmk_iir(
        input tmk_pkg::tmk_sample_t y,
        input tmk_pkg::tmk_sample_t x
    );
        logic signed [`TMK_SAMPLE_W:0] d;
        d = $signed({1'b0, x}) - $signed({1'b0, y});
        d = d >>> `TMK_IIR_SHIFT;
        if (d == '0)
        begin
            d = (x > y) ? 11'sh001 : ((x < y) ? -11'sh001 : 11'sh000);
        end
        return y + d[`TMK_SAMPLE_W-1:0];
    endfunction
endmodule // tmk_top

/* test/tmk_top_assertions.sv */
`timescale 1ns/100ps
`include "tmk_map.svh"
// ---------------------------------------------------------------
// Port checker
// ---------------------------------------------------------------
module tmk_top_assertions (
    input wire logic                    clk,
    input wire logic                    sys_rst,
    input wire logic                    proc_hold,
    input wire logic [`TMK_HITS_W-1:0]  min_hits,
    input wire logic                    manual_load,
    input wire logic                    cal_start,
    input wire tmk_pkg::tmk_skews_t     skew,
    input wire logic                    cal_busy,
    input wire logic [`TMK_NCH-1:0]     chan_locked,
    input wire logic [`TMK_NCH-1:0]     header_seen,
    input wire logic [`TMK_NCH-1:0]     start_event,
    input wire tmk_pkg::tmk_word_t      data_out,
    input wire logic                    data_valid
);
    logic [4:0] eff_hits;
    logic [4:0] fired;
    logic       fines_zero;

    // Zero coincidence setting acts as one
    always_comb
    begin
        eff_hits = (min_hits == '0) ? 5'h01 : {1'b0, min_hits};
        fired = 5'($countones(header_seen));
        fines_zero = 1'b1;
        for (int c = 0; c < `TMK_NCH; c++)
            if (skew[c].fine != '0)
                fines_zero = 1'b0;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence cal_begin;
        $rose(cal_busy);
    endsequence

    event_all_a: assert property (start_event != '0 |-> start_event == '1)
        else $error("event start not on every channel");
    event_gate_a: assert property (start_event[0] |-> fired >= $past(eff_hits) && fired != '0)
        else $error("event start without enough header pulses");
    event_missed_a: assert property (fired >= $past(eff_hits) |-> start_event[0])
        else $error("coincidence gave no event start");
    header_pulse_a: assert property (header_seen != '0 |=> header_seen == '0)
        else $error("header pulse longer than one cycle");
    header_locked_a: assert property (header_seen != '0 |-> (header_seen & ~chan_locked) == '0)
        else $error("header pulse from unlocked channel");
    header_word_a: assert property (header_seen != '0 |-> data_valid)
        else $error("header pulse without consumed word");
    lock_on_word_a: assert property (chan_locked != $past(chan_locked) |-> data_valid)
        else $error("lock changed without consumed word");
    data_hold_a: assert property (!data_valid |-> $stable(data_out))
        else $error("sample word changed without valid");
    stall_a: assert property (proc_hold |=> !data_valid)
        else $error("word consumed during hold");
    skew_hold_a: assert property (!$past(cal_busy) && !$past(manual_load) && !$past(cal_start)
        |-> $stable(skew))
        else $error("skew changed while idle");
    cal_fine_a: assert property (cal_begin |-> fines_zero)
        else $error("scan did not start at phase zero");
endmodule // tmk_top_assertions

bind tmk_top tmk_top_assertions tmk_top_assertions_i (.clk(clk), .sys_rst(sys_rst),
    .proc_hold(proc_hold), .min_hits(min_hits), .manual_load(manual_load),
    .cal_start(cal_start), .skew(skew), .cal_busy(cal_busy), .chan_locked(chan_locked),
    .header_seen(header_seen), .start_event(start_event), .data_out(data_out),
    .data_valid(data_valid));

/* test/tmk_delay_model.sv */
`timescale 1ns/100ps
`include "tmk_map.svh"
// ---------------------------------------------------------------
// Delay chips: tick stream with per-fibre whole-cycle delay
// ---------------------------------------------------------------
module tmk_delay_model (
    input wire logic                 clk,
    input wire logic                 sys_rst,
    input wire logic                 raw_ready,
    input wire logic [`TMK_NCH-1:0]  hdr_mask,
    input wire tmk_pkg::tmk_skews_t  skew,
    output tmk_pkg::tmk_word_t       raw_data,
    output logic                     raw_valid
);
    localparam tmk_pkg::tmk_sample_t LOW_LVL  = 10'h100;
    localparam tmk_pkg::tmk_sample_t HIGH_LVL = 10'h22C;
    logic [6:0] pos;
    logic       run;

    // Stops at once on ready low; the three words still in flight fill the allowed slack exactly
    assign raw_valid = run & raw_ready;

    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
        begin
            pos <= 7'h00;
            run <= 1'b0;
        end
        else
        begin
            run <= 1'b1;
            if (raw_valid)
                pos <= (pos == 7'h45) ? 7'h00 : pos + 7'h01;
        end

    // Fine phase not modelled: every phase samples cleanly
    always_comb
    begin
        int ph;
        tmk_pkg::tmk_sample_t lvl;
        ph  = 0;
        lvl = LOW_LVL;
        for (int c = 0; c < `TMK_NCH; c++)
        begin
            ph = (int'(pos) + 140 - int'(skew[c].coarse) % 70) % 70;
            lvl = (ph >= 68 || (ph == 0 && hdr_mask[c])) ? HIGH_LVL : LOW_LVL;
            raw_data[c] = raw_valid ? lvl : ~lvl;
        end
    end
endmodule // tmk_delay_model

/* test/test_tmk_top.sv */
`timescale 1ns/100ps
`include "tmk_map.svh"
`define CHK(what, exp, got) \
    begin \
        checked++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got); \
        end \
    end

module test_tmk_top;
    localparam logic [11:0] ALL = 12'hFFF;
    logic                   clk, sys_rst, raw_valid, raw_ready, proc_hold, manual_load;
    logic                   cal_start, cal_busy, data_valid;
    logic [`TMK_HITS_W-1:0] min_hits;
    logic [11:0]            hdr_mask, chan_locked, header_seen, start_event;
    tmk_pkg::tmk_word_t     raw_data, data_out;
    tmk_pkg::tmk_skews_t    manual_skew, skew;
    int                     fails, checked;

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    tmk_top #(.DEPTH(8), .FRAME_HOLD(9'h010), .CAL_SETTLE(16'h0010)) tmk_top_i (
        .clk(clk), .sys_rst(sys_rst), .raw_data(raw_data), .raw_valid(raw_valid),
        .raw_ready(raw_ready), .proc_hold(proc_hold), .min_hits(min_hits),
        .manual_load(manual_load), .manual_skew(manual_skew), .cal_start(cal_start),
        .skew(skew), .cal_busy(cal_busy), .chan_locked(chan_locked),
        .header_seen(header_seen), .start_event(start_event), .data_out(data_out),
        .data_valid(data_valid));
    tmk_delay_model tmk_delay_model_i (.clk(clk), .sys_rst(sys_rst), .raw_ready(raw_ready),
        .hdr_mask(hdr_mask), .skew(skew), .raw_data(raw_data), .raw_valid(raw_valid));

    task automatic close_out;
        $display("checks %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic give_up(input string what);
        fails++;
        $display("unexpected %s: expected completion, seen timeout", what);
        close_out();
    endtask

    task automatic wait_lock(input logic [11:0] want, input int lim);
        for (int i = 0; i < lim && chan_locked !== want; i++)
            step(1);
        `CHK("lock", want, chan_locked)
        if (chan_locked !== want)
            close_out();
    endtask

    task automatic reset_check;
        step(5);
        `CHK("lock in reset", 12'h000, chan_locked)
        `CHK("skew in reset", 144'h0, skew)
        sys_rst = 1'b0;
        step(2);
        `CHK("ready", 1'b1, raw_ready)
    endtask

    task automatic lock_check;
        wait_lock(ALL, 3000);
        step(140);
        `CHK("lock kept", ALL, chan_locked)
    endtask

    task automatic header_try(input logic [11:0] mask, input logic [3:0] hits, input logic ev);
        min_hits = hits;
        hdr_mask = mask;
        for (int i = 0; i < 200 && header_seen === 12'h000; i++)
            step(1);
        `CHK("header", mask, header_seen)
        `CHK("event", ev ? ALL : 12'h000, start_event)
        // Header word itself: marked fibres high, the rest at the tick's low level
        for (int c = 0; c < `TMK_NCH; c++)
        begin
            `CHK("header word", mask[c] ? 10'h22C : 10'h100, data_out[c])
        end
        hdr_mask = 12'h000;
        step(150);
        `CHK("lock after header", ALL, chan_locked)
    endtask

    task automatic buffer_fill;
        proc_hold = 1'b1;
        for (int i = 0; i < 20 && raw_ready !== 1'b0; i++)
            step(1);
        `CHK("ready full", 1'b0, raw_ready)
        step(10);
        `CHK("valid held", 1'b0, data_valid)
        proc_hold = 1'b0;
        for (int i = 0; i < 30 && raw_ready !== 1'b1; i++)
            step(1);
        `CHK("ready drained", 1'b1, raw_ready)
        step(150);
        `CHK("no word lost", ALL, chan_locked)
    endtask

    task automatic load_skew(input logic [6:0] coarse3);
        manual_skew = '0;
        manual_skew[3].coarse = coarse3;
        manual_load = 1'b1;
        step(1);
        manual_load = 1'b0;
        `CHK("manual skew", manual_skew, skew)
    endtask

    task automatic realign;
        load_skew(7'h05);
        for (int i = 0; i < 200 && chan_locked[3] !== 1'b0; i++)
            step(1);
        `CHK("lock lost", 12'hFF7, chan_locked)
        wait_lock(ALL, 300);
        load_skew(7'h00);
        wait_lock(ALL, 300);
    endtask

    task automatic calibrate;
        cal_start = 1'b1;
        step(1);
        cal_start = 1'b0;
        `CHK("cal busy", 1'b1, cal_busy)
        for (int i = 0; i < 1500 && cal_busy !== 1'b0; i++)
            step(1);
        if (cal_busy !== 1'b0)
            give_up("calibration");
        for (int c = 0; c < `TMK_NCH; c++)
        begin
            `CHK("fine", 5'h1F, skew[c].fine)
            `CHK("coarse", 7'h00, skew[c].coarse)
        end
        wait_lock(ALL, 300);
    endtask

    initial
    begin
        fails = 0;
        checked = 0;
        sys_rst = 1'b1;
        proc_hold = 1'b0;
        min_hits = 4'h1;
        manual_load = 1'b0;
        manual_skew = '0;
        cal_start = 1'b0;
        hdr_mask = 12'h000;
        reset_check();
        lock_check();
        header_try(12'h007, 4'h4, 1'b0);
        header_try(12'h00F, 4'h4, 1'b1);
        header_try(12'h001, 4'h0, 1'b1);
        header_try(12'hFFE, 4'hC, 1'b0);
        header_try(ALL, 4'hC, 1'b1);
        buffer_fill();
        realign();
        calibrate();
        close_out();
    end
endmodule // test_tmk_top
